// File: logic/bfd_pkg.sv
// Package with constants and types of the bit-field deposit and extract unit.
package bfd_pkg;

  // ****************************************************************
  // Word layout
  // ****************************************************************
  localparam int WORD_W    = 40;
  localparam int FIX_W     = 32;
  localparam int FIX_LSB   = 8;
  localparam int POS_LSB   = 0;
  localparam int POS_W     = 6;
  localparam int LEN_LSB   = 6;
  localparam int LEN_W     = 6;
  localparam int SHF_LSB   = 0;
  localparam int SHF_W     = 8;
  localparam logic [6:0] FIX_LIMIT = 7'h20;

  // ****************************************************************
  // Operations
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_FIELD_DEPOSIT         = 3'b000,
    OP_FIELD_DEPOSIT_OR      = 3'b001,
    OP_FIELD_DEPOSIT_SIGN    = 3'b010,
    OP_FIELD_DEPOSIT_SIGN_OR = 3'b011,
    OP_FIELD_EXTRACT         = 3'b100,
    OP_FIELD_EXTRACT_SIGN    = 3'b101,
    OP_EXPONENT              = 3'b110
  } bfd_op_e;

  // ****************************************************************
  // Register port
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_CLEAR   = 8'h04;
  localparam logic [7:0] ADDR_ENABLE  = 8'h08;
  localparam logic [7:0] ADDR_CONTROL = 8'h0C;
  localparam logic [7:0] ADDR_FLAGS   = 8'h10;
  localparam int EVT_W        = 3;
  localparam int EVT_DONE     = 0;
  localparam int EVT_OVERFLOW = 1;
  localparam int EVT_ZERO     = 2;
  localparam int CTL_UNIT_ON  = 0;
  localparam logic [2:0] STATUS_RESET  = 3'h0;
  localparam logic [2:0] ENABLE_RESET  = 3'h0;
  localparam logic       CONTROL_RESET = 1'b1;

endpackage

// File: logic/bfd_unit.sv
// Bit-field deposit, extract and exponent unit with status register port.
//
// What this block does
// - Plain deposit places source field at position, other bits zero.
// - Plain deposit, sign deposit and extracts clear bits 7 to 0; OR deposits keep them from the old destination.
// - Position and length are six bits each, values 0 to 63.
// - Position and length come from control operand or immediate fields.
// - Each deposit sets overflow when position plus length exceeds 32.
// - Deposit and extract set zero flag when the final result is zero.
// - Deposit and extract always clear the sign flag.
// - OR deposit merges positioned field with old destination.
// - Sign deposit extends field top bit upward unless off-scale.
// - Sign OR deposit ORs sign-extended field into old destination.
// - Plain extract right-aligns the field at position, bits above zero.
// - Extracts set overflow when position plus length exceeds 32.
// - Sign extract extends field top bit upward unless off-scale.
// - Exponent extraction writes the shift amount field.
// - Exponent is the negated count of leading sign bits minus one.
// - Exponent: sign flag from source bit 39, zero flag if zero.
`timescale 1ns/100ps
`default_nettype none

module bfd_unit (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      opValid,
  input  wire bfd_pkg::bfd_op_e          opCode,
  input  wire logic                      useImmediate,
  input  wire logic [5:0]                fieldStartPosition,
  input  wire logic [5:0]                fieldLength,
  input  wire logic [39:0]               sourceOperand,
  input  wire logic [39:0]               controlOperand,
  input  wire logic [39:0]               destinationOld,
  output logic                           resultValid,
  output logic [39:0]                    destinationRegister,
  output logic                           shifterZeroFlag,
  output logic                           shifterOverflowFlag,
  output logic                           shifterSignFlag,
  input  wire logic [bfd_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [bfd_pkg::DATA_W-1:0] regWrData,
  input  wire logic                      regWrStrobe,
  input  wire logic                      regRdStrobe,
  output logic [bfd_pkg::DATA_W-1:0]     regRdData,
  output logic                           irq
);
  import bfd_pkg::*;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Ones in the lowest n bits; 32 or more gives a full mask.
  function automatic logic [31:0] lowMask(input logic [6:0] n);
    if (n >= FIX_LIMIT) begin
      lowMask = 32'hFFFFFFFF;
    end else begin
      lowMask = ~(32'hFFFFFFFF << n[4:0]);
    end
  endfunction

  // Leading bits equal to bit 31, bit 31 itself included.
  function automatic logic [5:0] signRun(input logic [31:0] v);
    logic stop;
    stop    = 1'b0;
    signRun = 6'h01;
    for (int i = 30; i >= 0; i--) begin
      if (!stop && v[i] == v[31]) begin
        signRun = signRun + 6'h01;
      end else begin
        stop = 1'b1;
      end
    end
  endfunction

  // ****************************************************************
  // Operand selection
  // ****************************************************************
  logic [5:0]  pos;
  logic [5:0]  len;
  logic [6:0]  topSum;
  logic [31:0] srcFix;
  logic [31:0] lenMask;
  logic        inScale;

  always_comb begin
    if (useImmediate) begin
      pos = fieldStartPosition;
      len = fieldLength;
    end else begin
      pos = controlOperand[FIX_LSB+POS_LSB +: POS_W];
      len = controlOperand[FIX_LSB+LEN_LSB +: LEN_W];
    end
  end

  assign srcFix  = sourceOperand[FIX_LSB +: FIX_W];
  assign topSum  = {1'b0, pos} + {1'b0, len};
  assign lenMask = lowMask({1'b0, len});
  assign inScale = (len != 6'h00) && (topSum <= FIX_LIMIT);

  // ****************************************************************
  // Datapath
  // ****************************************************************
  logic [63:0] depWide;
  logic [63:0] extWide;
  logic [31:0] depPlain;
  logic [31:0] depSign;
  logic [31:0] extPlain;
  logic [31:0] extSign;
  logic [31:0] aboveField;
  logic [31:0] aboveExtract;
  logic        depTop;
  logic        extTop;
  logic [7:0]  exponent;

  assign depWide      = {32'h0, srcFix & lenMask} << pos;
  assign depPlain     = depWide[31:0];
  assign aboveField   = ~lowMask(topSum);
  assign depTop       = srcFix[5'(len - 6'h01)];
  assign depSign      = (inScale && depTop) ? (depPlain | aboveField)
                                            : depPlain;
  assign extWide      = {32'h0, srcFix} >> pos;
  assign extPlain     = extWide[31:0] & lenMask;
  assign aboveExtract = ~lenMask;
  assign extTop       = srcFix[5'(topSum - 7'h01)];
  assign extSign      = (inScale && extTop) ? (extPlain | aboveExtract)
                                            : extPlain;
  assign exponent     = 8'h01 - {2'b00, signRun(srcFix)};

  logic [39:0] next_result;
  logic        next_zero;
  logic        next_overflow;
  logic        next_sign;

  always_comb begin
    next_result   = '0;
    next_overflow = topSum > FIX_LIMIT;
    next_sign     = 1'b0;
    case (opCode)
      OP_FIELD_DEPOSIT: begin
        next_result = {depPlain, 8'h00};
      end
      OP_FIELD_DEPOSIT_OR: begin
        next_result = destinationOld | {depPlain, 8'h00};
      end
      OP_FIELD_DEPOSIT_SIGN: begin
        next_result = {depSign, 8'h00};
      end
      OP_FIELD_DEPOSIT_SIGN_OR: begin
        next_result = destinationOld | {depSign, 8'h00};
      end
      OP_FIELD_EXTRACT: begin
        next_result = {extPlain, 8'h00};
      end
      OP_FIELD_EXTRACT_SIGN: begin
        next_result = {extSign, 8'h00};
      end
      OP_EXPONENT: begin
        next_result[FIX_LSB+SHF_LSB +: SHF_W] = exponent;
        next_overflow = 1'b0;
        next_sign     = srcFix[31];
      end
      default: begin
        next_overflow = 1'b0;
      end
    endcase
    if (opCode == OP_EXPONENT) begin
      next_zero = exponent == 8'h00;
    end else begin
      next_zero = next_result == 40'h0;
    end
  end

  // ****************************************************************
  // Result registers
  // ****************************************************************
  logic    unitOn;
  logic    accept;
  bfd_op_e lastOp;

  assign accept = opValid && unitOn;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resultValid         <= 1'b0;
      destinationRegister <= '0;
      shifterZeroFlag     <= 1'b0;
      shifterOverflowFlag <= 1'b0;
      shifterSignFlag     <= 1'b0;
      lastOp              <= OP_FIELD_DEPOSIT;
    end else begin
      resultValid <= accept;
      if (accept) begin
        destinationRegister <= next_result;
        shifterZeroFlag     <= next_zero;
        shifterOverflowFlag <= next_overflow;
        shifterSignFlag     <= next_sign;
        lastOp              <= opCode;
      end
    end
  end

  // ****************************************************************
  // Register port and interrupt
  // ****************************************************************
  logic [EVT_W-1:0] intStatus;
  logic [EVT_W-1:0] intEnable;
  logic [EVT_W-1:0] next_status;
  logic [EVT_W-1:0] next_enable;
  logic [EVT_W-1:0] events;
  logic [EVT_W-1:0] clearBits;
  logic             wrClear;
  logic             wrEnable;

  assign wrClear  = regWrStrobe && regAddr == ADDR_CLEAR;
  assign wrEnable = regWrStrobe && regAddr == ADDR_ENABLE;
  assign clearBits = wrClear ? regWrData[EVT_W-1:0] : '0;

  always_comb begin
    events               = '0;
    events[EVT_DONE]     = accept;
    events[EVT_OVERFLOW] = accept && next_overflow;
    events[EVT_ZERO]     = accept && next_zero;
  end

  // A new event wins over a clear arriving in the same cycle.
  assign next_status = (intStatus & ~clearBits) | events;
  assign next_enable = wrEnable ? regWrData[EVT_W-1:0] : intEnable;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      intStatus <= STATUS_RESET;
      intEnable <= ENABLE_RESET;
      irq       <= 1'b0;
    end else begin
      intStatus <= next_status;
      intEnable <= next_enable;
      irq       <= |(next_status & next_enable);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      unitOn <= CONTROL_RESET;
    end else if (regWrStrobe && regAddr == ADDR_CONTROL) begin
      unitOn <= regWrData[CTL_UNIT_ON];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdData <= '0;
    end else if (regRdStrobe) begin
      case (regAddr)
        ADDR_STATUS:  regRdData <= {29'h0, intStatus};
        ADDR_ENABLE:  regRdData <= {29'h0, intEnable};
        ADDR_CONTROL: regRdData <= {31'h0, unitOn};
        ADDR_FLAGS:   regRdData <= {29'h0, shifterSignFlag,
                                    shifterOverflowFlag, shifterZeroFlag};
        default:      regRdData <= '0;
      endcase
    end else begin
      regRdData <= '0;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic isField;
  assign isField = lastOp != OP_EXPONENT;

  property p_ext_clear;
    resultValid && lastOp != OP_FIELD_DEPOSIT_OR
      && lastOp != OP_FIELD_DEPOSIT_SIGN_OR
      |-> destinationRegister[7:0] == 8'h00;
  endproperty
  a_ext_clear: assert property (p_ext_clear)
    else $error("Extension byte not cleared.");

  property p_overflow;
    accept && opCode <= OP_FIELD_EXTRACT_SIGN
      |=> shifterOverflowFlag == ($past(topSum) > FIX_LIMIT);
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("Overflow flag does not match position plus length.");

  property p_zero;
    resultValid && isField
      |-> shifterZeroFlag == (destinationRegister == 40'h0);
  endproperty
  a_zero: assert property (p_zero)
    else $error("Zero flag does not match result.");

  property p_sign_clear;
    resultValid && isField |-> !shifterSignFlag;
  endproperty
  a_sign_clear: assert property (p_sign_clear)
    else $error("Sign flag set by a field operation.");

  property p_exp_flags;
    accept && opCode == OP_EXPONENT
      |=> shifterSignFlag == $past(sourceOperand[39]) && !shifterOverflowFlag
          && shifterZeroFlag == (destinationRegister[15:8] == 8'h00);
  endproperty
  a_exp_flags: assert property (p_exp_flags)
    else $error("Exponent flags wrong.");

  property p_extract_top;
    accept && opCode == OP_FIELD_EXTRACT
      |=> (destinationRegister[39:8] & ~$past(lenMask)) == 32'h0;
  endproperty
  a_extract_top: assert property (p_extract_top)
    else $error("Bits above extracted field not zero.");

  property p_deposit_low;
    accept && opCode == OP_FIELD_DEPOSIT && pos < 6'h20
      |=> (destinationRegister[39:8] & lowMask({1'b0, $past(pos)})) == 32'h0;
  endproperty
  a_deposit_low: assert property (p_deposit_low)
    else $error("Bits below deposited field not zero.");

  property p_or_keep;
    accept && opCode == OP_FIELD_DEPOSIT_OR
      |=> (destinationRegister & $past(destinationOld))
          == $past(destinationOld);
  endproperty
  a_or_keep: assert property (p_or_keep)
    else $error("OR deposit lost old destination bits.");

  property p_valid;
    resultValid == $past(opValid && unitOn);
  endproperty
  a_valid: assert property (p_valid)
    else $error("Result valid not one cycle after accepted operation.");

  property p_irq;
    irq == |(intStatus & intEnable);
  endproperty
  a_irq: assert property (p_irq)
    else $error("Interrupt level does not follow enabled status.");

  c_overflow: cover property (accept && opCode == OP_FIELD_DEPOSIT
                              && topSum > FIX_LIMIT);
  c_extract_sign: cover property (accept && opCode == OP_FIELD_EXTRACT_SIGN
                                  && inScale && extTop);
  c_exponent: cover property (accept && opCode == OP_EXPONENT);
  c_irq: cover property (!irq ##1 irq);

endmodule

`default_nettype wire

// File: tb/bfd_regfile_model.sv
// Register file model that feeds and takes back the destination word.
`timescale 1ns/100ps
`default_nettype none

module bfd_regfile_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        opValid,
  input  wire logic        resultValid,
  input  wire logic        preloadEn,
  input  wire logic [1:0]  selIdx,
  input  wire logic [39:0] preloadData,
  input  wire logic [39:0] destinationRegister,
  output logic [39:0]      destinationOld
);
  logic [39:0] mem [4];
  logic [1:0]  wrIdx;

  // No forwarding: a result lands one edge after resultValid.
  assign destinationOld = mem[selIdx];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrIdx <= 2'h0;
      for (int i = 0; i < 4; i++) begin
        mem[i] <= 40'h0;
      end
    end else begin
      if (opValid) begin
        wrIdx <= selIdx;
      end
      if (preloadEn) begin
        mem[selIdx] <= preloadData;
      end
      if (resultValid) begin
        mem[wrIdx] <= destinationRegister;
      end
    end
  end
endmodule

`default_nettype wire

// File: tb/tb.sv
// Self-checking bench of the bit-field deposit and extract unit.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin checksDone++; if ((ex) !== (got)) begin \
  fails++; $display("mismatch %s exp %h got %h", nm, ex, got); end end

module tb;
  import bfd_pkg::*;
  typedef struct packed {logic [39:0] w; logic z, v, s;} bfd_exp_s;
  logic        clk = 0, rst = 1, opValid = 0, useImm = 0, preEn = 0;
  logic        rdS = 0, wrS = 0, rv, zf, vf, sf, irq;
  bfd_op_e     opCode = OP_FIELD_DEPOSIT;
  logic [5:0]  pos = 0, len = 0;
  logic [39:0] src = 0, ctl = 0, preD = 0, old, dst;
  logic [39:0] shadow [4];
  logic [7:0]  addr = 0;
  logic [31:0] wd = 0, rd;
  logic [1:0]  idx = 0;
  logic [5:0]  tp [8] = '{0, 13, 31, 32, 20, 0, 63, 5};
  logic [5:0]  tl [8] = '{32, 14, 1, 1, 13, 0, 63, 27};
  bfd_exp_s    q [$];
  bfd_exp_s    last, got;
  int          fails = 0, checksDone = 0, cur = 0, k;

  bfd_unit DUT (.clk(clk), .rst(rst), .opValid(opValid), .opCode(opCode),
    .useImmediate(useImm), .fieldStartPosition(pos), .fieldLength(len),
    .sourceOperand(src), .controlOperand(ctl), .destinationOld(old),
    .resultValid(rv), .destinationRegister(dst), .shifterZeroFlag(zf),
    .shifterOverflowFlag(vf), .shifterSignFlag(sf), .regAddr(addr),
    .regWrData(wd), .regWrStrobe(wrS), .regRdStrobe(rdS), .regRdData(rd),
    .irq(irq));
  bfd_regfile_model RF (.clk(clk), .rst(rst), .opValid(opValid),
    .resultValid(rv), .preloadEn(preEn), .selIdx(idx), .preloadData(preD),
    .destinationRegister(dst), .destinationOld(old));

  initial begin
    forever #25 clk = ~clk;
  end

  function automatic bfd_exp_s ref_calc(bfd_op_e c, logic [39:0] s, o,
                                        logic [5:0] ps, ln);
    int p, l, n;
    logic [63:0] m, f;
    bfd_exp_s e;
    p = ps;
    l = ln;
    e = '0;
    f = '0;
    m = (l >= 32) ? 64'hFFFFFFFF : (64'h1 << l) - 64'h1;
    if (c == OP_FIELD_EXTRACT || c == OP_FIELD_EXTRACT_SIGN) begin
      f = ({32'h0, s[39:8]} >> p) & m;
      if (c[0] && l != 0 && p + l <= 32 && f[l-1]) f = f | ~m;
      e.v = p + l > 32;
    end else if (!c[2]) begin
      f = ({32'h0, s[39:8]} & m) << p;
      if (c[1] && l != 0 && p + l <= 32 && f[p+l-1])
        f = f | ~((64'h1 << (p + l)) - 64'h1);
      e.v = p + l > 32;
    end
    e.w = {f[31:0], 8'h00};
    if (c == OP_FIELD_DEPOSIT_OR || c == OP_FIELD_DEPOSIT_SIGN_OR)
      e.w = e.w | o;
    e.z = e.w == 40'h0;
    if (c == OP_EXPONENT) begin
      n = 0;
      while (n < 32 && s[39-n] == s[39]) n++;
      e.w = {24'h0, 8'(1 - n), 8'h00};
      e.z = 8'(1 - n) == 8'h00;
      e.s = s[39];
    end
    return e;
  endfunction

  task automatic do_op(bfd_op_e c, logic [5:0] p, l, logic on);
    logic [39:0] s;
    logic        im;
    s = {$urandom, 8'($urandom)};
    im = 1'($urandom);
    @(posedge clk);
    opValid <= 1;
    opCode <= c;
    src <= s;
    useImm <= im;
    idx <= cur[1:0];
    pos <= im ? p : 6'($urandom);
    len <= im ? l : 6'($urandom);
    ctl <= im ? {$urandom, 8'($urandom)} : {20'($urandom), l, p, 8'hA5};
    if (on) begin
      last = ref_calc(c, s, shadow[cur[1:0]], p, l);
      q.push_back(last);
      shadow[cur[1:0]] = last.w;
    end
    cur++;
  endtask

  task automatic idle();
    @(posedge clk);
    opValid <= 0;
  endtask

  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    wrS <= 1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wrS <= 0;
    @(negedge clk);
  endtask

  task automatic rd_reg(logic [7:0] a, logic [31:0] ex, string nm);
    @(posedge clk);
    rdS <= 1;
    addr <= a;
    @(posedge clk);
    rdS <= 0;
    @(negedge clk);
    `CHK(nm, ex, rd)
  endtask

  task automatic drain();
    k = 0;
    while (q.size() != 0 && k < 20) begin
      @(posedge clk);
      k++;
    end
    if (q.size() != 0) begin
      fails++;
      $display("mismatch queue exp 0 got %0d", q.size());
      end_of_test();
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // A result with no pending note is an unexpected answer.
  always @(negedge clk) begin
    if (rv === 1'b1) begin
      if (q.size() == 0) begin
        fails++;
        $display("mismatch result exp none got %h", dst);
      end else begin
        got = q.pop_front();
        `CHK("dest", got.w, dst)
        `CHK("fix", got.w[39:8], dst[39:8])
        `CHK("top", got.w[39:32], dst[39:32])
        `CHK("ext", got.w[7:0], dst[7:0])
        `CHK("shf", got.w[15:8], dst[15:8])
        `CHK("zero", got.z, zf)
        `CHK("ovf", got.v, vf)
        `CHK("sign", got.s, sf)
      end
    end
  end

  initial begin
    repeat (50000) @(posedge clk);
    fails++;
    $display("mismatch watchdog exp done got hang");
    end_of_test();
  end

  initial begin
    k = $urandom(78);
    repeat (4) @(posedge clk);
    rst <= 0;
    rd_reg(ADDR_STATUS, 32'h0, "status");
    rd_reg(ADDR_ENABLE, 32'h0, "enable");
    rd_reg(ADDR_CONTROL, 32'h1, "control");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      preEn <= 1;
      idx <= 2'(i);
      shadow[i] = {$urandom, 8'($urandom)};
      preD <= shadow[i];
    end
    @(posedge clk);
    preEn <= 0;
    for (int c = 0; c < 8; c++) begin
      for (int j = 0; j < 8; j++) begin
        do_op(bfd_op_e'(3'(c)), tp[j], tl[j], 1);
      end
    end
    idle();
    drain();
    $display("test boundaries done");
    repeat (300) do_op(bfd_op_e'(3'($urandom_range(6, 0))), 6'($urandom),
                       6'($urandom), 1);
    idle();
    drain();
    $display("test random done");
    rd_reg(ADDR_STATUS, 32'h7, "status");
    rd_reg(ADDR_FLAGS, {29'h0, last.s, last.v, last.z}, "flags");
    rd_reg(ADDR_CLEAR, 32'h0, "clear");
    rd_reg(8'h20, 32'h0, "unmapped");
    `CHK("irq", 1'b0, irq)
    wr_reg(ADDR_ENABLE, 32'h1);
    `CHK("irq", 1'b1, irq)
    wr_reg(ADDR_CLEAR, 32'h1);
    `CHK("irq", 1'b0, irq)
    rd_reg(ADDR_STATUS, 32'h6, "status");
    wr_reg(ADDR_ENABLE, 32'h4);
    `CHK("irq", 1'b1, irq)
    wr_reg(ADDR_CLEAR, 32'h7);
    `CHK("irq", 1'b0, irq)
    rd_reg(ADDR_ENABLE, 32'h4, "enable");
    $display("test interrupt done");
    wr_reg(ADDR_CONTROL, 32'h0);
    do_op(OP_FIELD_DEPOSIT, 6'd0, 6'd8, 0);
    idle();
    repeat (3) idle();
    rd_reg(ADDR_STATUS, 32'h0, "status");
    wr_reg(ADDR_CONTROL, 32'h1);
    do_op(OP_FIELD_EXTRACT, 6'd4, 6'd8, 1);
    idle();
    drain();
    $display("test refusal done");
    end_of_test();
  end
endmodule

`default_nettype wire
